// ---- common/tdc_pkg.sv ----
// Purpose: Shared constants for the test level control register bank.
// Assumes: AHB-Lite, 32-bit data, one aligned word per register.
// Notes:   Register indices are kept and byte addresses are index times four.
package tdc_pkg;
  localparam logic [7:0]  POS_IDX        = 8'h10;
  localparam logic [7:0]  NEG_IDX        = 8'h11;
  localparam logic [9:0]  POS_ADDR       = {POS_IDX, 2'b00};
  localparam logic [9:0]  NEG_ADDR       = {NEG_IDX, 2'b00};
  localparam int          ADDR_W         = 10;
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam int          ROUTE_BIT      = 7;
  localparam int          CODE_HI        = 4;
  localparam logic [7:0]  WRITE_MASK     = 8'h9F;
  localparam logic [4:0]  RISE_LAST      = 5'h09;
  localparam logic [4:0]  FALL_FIRST     = 5'h11;
  localparam logic [4:0]  FALL_LAST      = 5'h19;
  localparam logic [4:0]  RSVD_FIRST     = 5'h0A;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'b10;
  localparam logic [1:0]  HTRANS_SEQ     = 2'b11;
  localparam logic [2:0]  HSIZE_WORD     = 3'b010;
  localparam logic [31:0] RDATA_ZERO     = 32'h0000_0000;
endpackage : tdc_pkg

// ---- rtl/tdc_level_check.sv ----
// Purpose: Flags whether a 5-bit level code is one of the nineteen listed codes.
// Assumes: Code is the low five bits of a test level register.
// Notes:   Used by the bank to report codes that software must not program.
`timescale 1ns/1ps
module tdc_level_check (
  input  wire logic [4:0] code,
  output logic            valid
);
  // Codes 00000..01001 rise from the midpoint, 10001..11001 fall below it.
  always_comb begin
    valid = (code <= tdc_pkg::RISE_LAST) ||
            ((code >= tdc_pkg::FALL_FIRST) && (code <= tdc_pkg::FALL_LAST));
  end
endmodule : tdc_level_check

// ---- rtl/tdc_regs.sv ----
// Purpose: AHB-Lite register bank holding the two test level generator controls.
// Assumes: Single word transfers, zero wait states, OKAY response only.
// Notes:   Level codes and route enables drive the analog generators directly.
`timescale 1ns/1ps
module tdc_regs (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             pos_route_enable,
  output logic      [4:0]  pos_level_code,
  output logic             neg_route_enable,
  output logic      [4:0]  neg_level_code,
  output logic             pos_code_reserved,
  output logic             neg_code_reserved
);
  logic [7:0]  pos_reg;
  logic [7:0]  neg_reg;
  logic [7:0]  next_pos_reg;
  logic [7:0]  next_neg_reg;
  logic        wr_pend;
  logic        next_wr_pend;
  logic [tdc_pkg::ADDR_W-1:0] wr_addr;
  logic [tdc_pkg::ADDR_W-1:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic        pos_ok;
  logic        neg_ok;
  logic        take;

  // Compares a decoded byte address with the address of one register.
  function automatic logic addr_hit(input logic [tdc_pkg::ADDR_W-1:0] addr,
                                    input logic [tdc_pkg::ADDR_W-1:0] target);
    return addr == target;
  endfunction : addr_hit

  // Places an eight-bit register in the low lane of an otherwise zero read word.
  function automatic logic [31:0] read_word(input logic [7:0] value);
    return {24'h00_0000, value};
  endfunction : read_word

  // Checks the programmed codes against the listed set.
  tdc_level_check u_pos_chk (.code(next_pos_reg[tdc_pkg::CODE_HI:0]), .valid(pos_ok));
  tdc_level_check u_neg_chk (.code(next_neg_reg[tdc_pkg::CODE_HI:0]), .valid(neg_ok));

  // Address phase accepted only for word sized NONSEQ or SEQ transfers.
  assign take = hsel && hready && (hsize == tdc_pkg::HSIZE_WORD) &&
                ((htrans == tdc_pkg::HTRANS_NONSEQ) || (htrans == tdc_pkg::HTRANS_SEQ));

  // Next values for the bus pipeline, the registers and read data.
  // A write lands at the edge that ends its data phase. A read taken in that
  // same cycle sees the value being written, so back to back accesses agree.
  always_comb begin
    next_pos_reg = pos_reg;
    next_neg_reg = neg_reg;
    next_wr_pend = take && hwrite;
    next_wr_addr = haddr[tdc_pkg::ADDR_W-1:0];
    next_hrdata  = tdc_pkg::RDATA_ZERO;
    if (wr_pend) begin
      if (addr_hit(wr_addr, tdc_pkg::POS_ADDR)) begin
        next_pos_reg = hwdata[7:0] & tdc_pkg::WRITE_MASK;
      end else if (addr_hit(wr_addr, tdc_pkg::NEG_ADDR)) begin
        next_neg_reg = hwdata[7:0] & tdc_pkg::WRITE_MASK;
      end
    end
    if (take && !hwrite) begin
      if (addr_hit(haddr[tdc_pkg::ADDR_W-1:0], tdc_pkg::POS_ADDR)) begin
        next_hrdata = read_word(next_pos_reg);
      end else if (addr_hit(haddr[tdc_pkg::ADDR_W-1:0], tdc_pkg::NEG_ADDR)) begin
        next_hrdata = read_word(next_neg_reg);
      end
    end
  end

  // Registers the bank and drives every output from a flip-flop.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_reg           <= tdc_pkg::REG_RESET;
      neg_reg           <= tdc_pkg::REG_RESET;
      wr_pend           <= 1'b0;
      wr_addr           <= '0;
      hrdata            <= tdc_pkg::RDATA_ZERO;
      hreadyout         <= 1'b1;
      hresp             <= 1'b0;
      pos_route_enable  <= tdc_pkg::REG_RESET[tdc_pkg::ROUTE_BIT];
      pos_level_code    <= tdc_pkg::REG_RESET[tdc_pkg::CODE_HI:0];
      neg_route_enable  <= tdc_pkg::REG_RESET[tdc_pkg::ROUTE_BIT];
      neg_level_code    <= tdc_pkg::REG_RESET[tdc_pkg::CODE_HI:0];
      pos_code_reserved <= 1'b0;
      neg_code_reserved <= 1'b0;
    end else begin
      pos_reg           <= next_pos_reg;
      neg_reg           <= next_neg_reg;
      wr_pend           <= next_wr_pend;
      wr_addr           <= next_wr_addr;
      hrdata            <= next_hrdata;
      hreadyout         <= 1'b1;
      hresp             <= 1'b0;
      pos_route_enable  <= next_pos_reg[tdc_pkg::ROUTE_BIT];
      pos_level_code    <= next_pos_reg[tdc_pkg::CODE_HI:0];
      neg_route_enable  <= next_neg_reg[tdc_pkg::ROUTE_BIT];
      neg_level_code    <= next_neg_reg[tdc_pkg::CODE_HI:0];
      pos_code_reserved <= !pos_ok;
      neg_code_reserved <= !neg_ok;
    end
  end

  // Bus phases of a write as the slave sees them: the address phase is taken at
  // one edge, and the data phase, with hwdata on the bus, ends at the next edge.
  sequence s_pos_addr;
    take && hwrite && (haddr[tdc_pkg::ADDR_W-1:0] == tdc_pkg::POS_ADDR);
  endsequence

  sequence s_neg_addr;
    take && hwrite && (haddr[tdc_pkg::ADDR_W-1:0] == tdc_pkg::NEG_ADDR);
  endsequence

  // A write in its data phase reaches the register outputs one edge later.
  sequence s_pos_write;
    wr_pend && (wr_addr == tdc_pkg::POS_ADDR);
  endsequence

  sequence s_neg_write;
    wr_pend && (wr_addr == tdc_pkg::NEG_ADDR);
  endsequence

  // A whole write transfer is its address phase followed by its data phase.
  sequence s_pos_transfer;
    s_pos_addr ##1 s_pos_write;
  endsequence

  sequence s_neg_transfer;
    s_neg_addr ##1 s_neg_write;
  endsequence

  // The route bit of a positive write drives the positive route output.
  AST_POS_ROUTE: assert property (@(posedge hclk) disable iff (!hresetn)
    s_pos_write |=> (pos_route_enable == $past(hwdata[tdc_pkg::ROUTE_BIT])))
    else $error("positive route not taken from write");

  // The code field of a positive write drives the positive level output.
  AST_POS_CODE: assert property (@(posedge hclk) disable iff (!hresetn)
    s_pos_write |=> (pos_level_code == $past(hwdata[tdc_pkg::CODE_HI:0])))
    else $error("positive code not taken from write");

  // The highest rising code is a listed level and is never flagged.
  AST_POS_RISE: assert property (@(posedge hclk) disable iff (!hresetn)
    (pos_level_code == tdc_pkg::RISE_LAST) |-> !pos_code_reserved)
    else $error("highest rising code flagged reserved");

  // The lowest falling code is a listed level and is never flagged.
  AST_POS_FALL: assert property (@(posedge hclk) disable iff (!hresetn)
    (pos_level_code == tdc_pkg::FALL_LAST) |-> !pos_code_reserved)
    else $error("lowest level code flagged reserved");

  // The first code past the rising run is reserved and must be flagged.
  AST_RESV_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
    (pos_level_code == tdc_pkg::RSVD_FIRST) |-> pos_code_reserved)
    else $error("reserved code not flagged");

  // The same reserved code must be flagged on the negative side too.
  AST_NEG_RESV: assert property (@(posedge hclk) disable iff (!hresetn)
    (neg_level_code == tdc_pkg::RSVD_FIRST) |-> neg_code_reserved)
    else $error("negative reserved code not flagged");

  // The route bit of a negative write drives the negative route output.
  AST_NEG_ROUTE: assert property (@(posedge hclk) disable iff (!hresetn)
    s_neg_write |=> (neg_route_enable == $past(hwdata[tdc_pkg::ROUTE_BIT])))
    else $error("negative route not taken from write");

  // The code field of a negative write drives the negative level output.
  AST_NEG_CODE: assert property (@(posedge hclk) disable iff (!hresetn)
    s_neg_write |=> (neg_level_code == $past(hwdata[tdc_pkg::CODE_HI:0])))
    else $error("negative code not taken from write");

  // The negative field shares the encoding, so its lowest level is listed.
  AST_NEG_FALL: assert property (@(posedge hclk) disable iff (!hresetn)
    (neg_level_code == tdc_pkg::FALL_LAST) |-> !neg_code_reserved)
    else $error("negative lowest level code flagged reserved");

  // A read of the negative register with no write in flight returns its outputs.
  AST_NEG_READ: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && !wr_pend && (haddr[tdc_pkg::ADDR_W-1:0] == tdc_pkg::NEG_ADDR)) |=>
      (hrdata[7:0] == {neg_route_enable, 2'b00, neg_level_code}))
    else $error("negative register readback wrong");

  // The negative outputs hold while no write to that register lands.
  AST_NEG_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
    !(wr_pend && (wr_addr == tdc_pkg::NEG_ADDR)) |=>
      ($stable(neg_level_code) && $stable(neg_route_enable)))
    else $error("negative register changed without write");

  // A read of the positive register with no write in flight returns its outputs.
  AST_POS_READ: assert property (@(posedge hclk) disable iff (!hresetn)
    (take && !hwrite && !wr_pend && (haddr[tdc_pkg::ADDR_W-1:0] == tdc_pkg::POS_ADDR)) |=>
      (hrdata[7:0] == {pos_route_enable, 2'b00, pos_level_code}))
    else $error("positive register readback wrong");

  // The positive outputs hold while no write to that register lands.
  AST_POS_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
    !(wr_pend && (wr_addr == tdc_pkg::POS_ADDR)) |=>
      ($stable(pos_level_code) && $stable(pos_route_enable)))
    else $error("positive register changed without write");

  // A full positive write stores its data with the read-only bits dropped.
  AST_POS_STORE: assert property (@(posedge hclk) disable iff (!hresetn)
    s_pos_transfer |=> (pos_reg == ($past(hwdata[7:0]) & tdc_pkg::WRITE_MASK)))
    else $error("positive write stored wrong value");

  // A full negative write stores its data with the read-only bits dropped.
  AST_NEG_STORE: assert property (@(posedge hclk) disable iff (!hresetn)
    s_neg_transfer |=> (neg_reg == ($past(hwdata[7:0]) & tdc_pkg::WRITE_MASK)))
    else $error("negative write stored wrong value");

  // Read data never shows the read-only bits or the upper lanes.
  AST_RSVD_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
    (hrdata[6:5] == 2'b00) && (hrdata[31:8] == 24'h00_0000))
    else $error("reserved bits read nonzero");
endmodule : tdc_regs

// ---- tb/tdc_regs_tb.sv ----
// Purpose: Self-checking bench for the test level control register bank.
// Assumes: Zero wait state slave; hready follows hreadyout.
// Notes:   Two monitors check read data and generator outputs against queued notes.
`timescale 1ns/1ps
module tdc_regs_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = tdc_pkg::HSIZE_WORD;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, p_en, n_en, p_rsv, n_rsv, rd_phase = 1'b0;
  logic [4:0]  p_code, n_code;
  logic [7:0]  pm = 8'h00, nm = 8'h00;
  logic [31:0] rd_q[$], out_q[$], seed = 32'h931b_98ae, d, a, got_out;
  logic        out_due = 1'b0;
  int          errors = 0, n_compared = 0, cycles = 0;
  // The clock toggles every half period of 5 ns.
  always #5 hclk = ~hclk;
  tdc_regs tdc_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pos_route_enable(p_en),
    .pos_level_code(p_code), .neg_route_enable(n_en), .neg_level_code(n_code),
    .pos_code_reserved(p_rsv), .neg_code_reserved(n_rsv));
  // Packs the generator outputs in the same order as the expected notes.
  assign got_out = {18'h0, p_en, p_code, p_rsv, n_en, n_code, n_rsv};
  // Step the xorshift sequence used for random write data.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  // Packs the expected generator outputs; unlisted codes raise the flag.
  function automatic logic [31:0] eo(input logic [7:0] p, input logic [7:0] n);
    logic rp, rn;
    rp = !(p[4:0] <= 5'h09 || (p[4:0] >= 5'h11 && p[4:0] <= 5'h19));
    rn = !(n[4:0] <= 5'h09 || (n[4:0] >= 5'h11 && n[4:0] <= 5'h19));
    return {18'h0, p[7], p[4:0], rp, n[7], n[4:0], rn};
  endfunction : eo
  // Compares one read word against its note.
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : chk_rd
  // Compares the packed generator outputs against their note.
  task automatic chk_out(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: outputs %h expected %h", $time, got, exp);
    end
  endtask : chk_out
  // Compares the ready and response pair, which must show ready and OKAY.
  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: response %b expected %b", $time, got, exp);
    end
  endtask : chk_resp
  // Notes the expected outputs; the monitor compares them at the next edge.
  task automatic note_out();
    out_q.push_back(eo(pm, nm));
    out_due <= 1'b1;
  endtask : note_out
  // Runs one transfer; each phase is held until hready is sampled high.
  task automatic bus(input logic [31:0] ad, input logic w, input logic [2:0] sz,
                     input logic [31:0] wd);
    @(posedge hclk);
    out_due <= 1'b0;
    haddr  <= ad;
    htrans <= tdc_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    hsize  <= sz;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans   <= 2'b00;
    hwdata   <= w ? wd : 32'h0000_0000;
    rd_phase <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_phase <= 1'b0;
  endtask : bus
  // Notes the expected read data, then reads.
  task automatic rd(input logic [31:0] ad, input logic [7:0] exp);
    rd_q.push_back({24'h0, exp});
    bus(ad, 1'b0, tdc_pkg::HSIZE_WORD, 32'h0000_0000);
  endtask : rd
  // Takes the oldest note when read data is sampled at the end of a data phase.
  always @(posedge hclk) begin
    if (rd_phase === 1'b1 && hreadyout === 1'b1 && rd_q.size() > 0) begin
      chk_rd(hrdata, rd_q.pop_front());
      chk_resp({hreadyout, hresp}, 2'b10);
    end
  end
  // Takes the oldest output note one edge after a write or a reset release.
  always @(posedge hclk) begin
    if (out_due === 1'b1 && out_q.size() > 0) begin
      chk_out(got_out, out_q.pop_front());
    end
  end
  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  // Cuts a hang short after a cycle ceiling well above the expected run.
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end
  // Main sequence: reset values, every code in both registers, refusals, reset again.
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    hsel    <= 1'b1;
    note_out();
    rd({22'h0, tdc_pkg::POS_ADDR}, 8'h00);
    rd({22'h0, tdc_pkg::NEG_ADDR}, 8'h00);
    for (int i = 0; i < 64; i++) begin
      seed = xs(seed);
      d = {seed[31:5], i[4:0]};
      a = {22'h0, i[5] ? tdc_pkg::NEG_ADDR : tdc_pkg::POS_ADDR};
      bus(a, 1'b1, tdc_pkg::HSIZE_WORD, d);
      if (i[5]) nm = d[7:0] & 8'h9F;
      else pm = d[7:0] & 8'h9F;
      // Reserved codes are written on purpose here, to see them flagged.
      note_out();
      rd(a, i[5] ? nm : pm);
    end
    bus(32'h0000_0048, 1'b1, tdc_pkg::HSIZE_WORD, 32'h0000_00FF);
    note_out();
    bus({22'h0, tdc_pkg::POS_ADDR}, 1'b1, 3'b000, 32'h0000_0081);
    note_out();
    rd(32'h0000_0048, 8'h00);
    rd({22'h0, tdc_pkg::POS_ADDR}, pm);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    pm = 8'h00;
    nm = 8'h00;
    note_out();
    rd({22'h0, tdc_pkg::NEG_ADDR}, 8'h00);
    rd({22'h0, tdc_pkg::POS_ADDR}, 8'h00);
    // Lets the monitors finish the last edge before any note is judged left over.
    repeat (2) @(posedge hclk);
    if (rd_q.size() != 0 || out_q.size() != 0) begin
      errors++;
      $display("mismatch at %0t: %0d notes left unchecked", $time, rd_q.size() + out_q.size());
    end
    end_of_test();
  end
endmodule : tdc_regs_tb
